//--- rtl/sfct_pkg.sv
// Constants shared by the serial flash host sequencer
// Operation
// - Send write latch set before modifying commands; the host does not send it itself, the user issues REQ_LATCH_SET first
// - Write latch clear code available to host
// - Status write sends opcode then one byte
// - High-speed read: opcode, address, dummy, data
// - Small area wipe opcode with address
// - Block wipe uses either of two codes
// - Whole array wipe uses either of two codes
// - Deep sleep opcode sent alone
// - Wait deep sleep entry time after deselect
// - Wait wake-up time before next command
// - Security word write opcode sent alone
// - Id read opcode followed by address phase
// - Status write busy limit forty milliseconds
// - Page program busy limit five milliseconds
// - Small wipe busy limit three hundred ms
// - Block wipe busy limit two seconds
// - Whole array wipe busy limit thirty seconds
package sfct_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] write_latch_set_cmd = 8'h06;
  localparam logic [7:0] write_latch_clear_cmd = 8'h04;
  localparam logic [7:0] status_write_cmd = 8'h01;
  localparam logic [7:0] status_read_cmd = 8'h05;
  localparam logic [7:0] fast_read_cmd = 8'h0B;
  localparam logic [7:0] small_area_wipe_cmd = 8'h20;
  localparam logic [7:0] block_wipe_cmd = 8'h52;
  localparam logic [7:0] block_wipe_alt_cmd = 8'hD8;
  localparam logic [7:0] array_wipe_cmd = 8'h60;
  localparam logic [7:0] array_wipe_alt_cmd = 8'hC7;
  localparam logic [7:0] page_program_cmd = 8'h02;
  localparam logic [7:0] deep_sleep_cmd = 8'hB9;
  localparam logic [7:0] wake_cmd = 8'hAB;
  localparam logic [7:0] security_word_write_cmd = 8'h2F;
  localparam logic [7:0] maker_part_id_read_cmd = 8'h90;
  // ==========================================================
  // Request codes on the user port
  localparam logic [3:0] REQ_LATCH_SET = 4'h0;
  localparam logic [3:0] REQ_LATCH_CLR = 4'h1;
  localparam logic [3:0] REQ_STATUS_WR = 4'h2;
  localparam logic [3:0] REQ_READ = 4'h3;
  localparam logic [3:0] REQ_SMALL_WIPE = 4'h4;
  localparam logic [3:0] REQ_BLOCK_WIPE = 4'h5;
  localparam logic [3:0] REQ_ARRAY_WIPE = 4'h6;
  localparam logic [3:0] REQ_PROGRAM = 4'h7;
  localparam logic [3:0] REQ_SLEEP = 4'h8;
  localparam logic [3:0] REQ_WAKE = 4'h9;
  localparam logic [3:0] REQ_SEC_WR = 4'hA;
  localparam logic [3:0] REQ_ID_READ = 4'hB;
  // ==========================================================
  // Timing, 20 MHz reference clock
  localparam int CLK_HZ = 20_000_000;
  localparam int SCK_HALF = 2;
  localparam int T_SLEEP_US = 10;
  localparam int T_WAKE_NS = 8800;
  localparam int T_PWRUP_US = 200;
  localparam int T_STATUS_WR_MS = 40;
  localparam int T_PAGE_PROG_MS = 5;
  localparam int T_BYTE_PROG_US = 300;
  localparam int T_SMALL_WIPE_MS = 300;
  localparam int T_BLOCK_WIPE_S = 2;
  localparam int T_ARRAY_WIPE_S = 30;
  localparam int SLEEP_CYC = (T_SLEEP_US * (CLK_HZ / 1_000_000));
  localparam int WAKE_CYC = (T_WAKE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam longint PWRUP_CYC = longint'(T_PWRUP_US) * (CLK_HZ / 1_000_000);
  localparam longint STATUS_WR_CYC = longint'(T_STATUS_WR_MS) * (CLK_HZ / 1000);
  localparam longint PAGE_PROG_CYC = longint'(T_PAGE_PROG_MS) * (CLK_HZ / 1000);
  localparam longint BYTE_PROG_CYC = longint'(T_BYTE_PROG_US) * (CLK_HZ / 1_000_000);
  localparam longint SMALL_WIPE_CYC = longint'(T_SMALL_WIPE_MS) * (CLK_HZ / 1000);
  localparam longint BLOCK_WIPE_CYC = longint'(T_BLOCK_WIPE_S) * CLK_HZ;
  localparam longint ARRAY_WIPE_CYC = longint'(T_ARRAY_WIPE_S) * CLK_HZ;
  localparam logic [9:0] POLL_GAP_CYC = 10'h0_3FF;
endpackage

//--- rtl/sfct_shifter.sv
// Byte-wide serial shifter driving clock and data, with pause
`timescale 1ns/1ps
module sfct_shifter
  import sfct_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic nrst, // Sync reset, low
  input wire logic start, // Begin one byte
  input wire logic [7:0] txByte, // Byte to send
  input wire logic pause, // Suspend transfer
  input wire logic serIn, // Data from device
  output logic busy, // Byte in flight
  output logic done, // Byte finished pulse
  output logic [7:0] rxByte, // Byte received
  output logic serClk, // Serial clock
  output logic serOut // Data to device
);
  logic [7:0] txSh;
  logic [2:0] bitCnt;
  logic [1:0] halfCnt;

  // ==========================================================
  // Mode 0: data changes on falling edge, sampled on rising
  always_ff @(posedge ref_clk)
  begin
    done <= 1'b0;
    if (!nrst)
    begin
      busy <= 1'b0;
      serClk <= 1'b0;
      serOut <= 1'b0;
      txSh <= 8'h00;
      rxByte <= 8'h00;
      bitCnt <= 3'h0;
      halfCnt <= 2'h0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      serOut <= txByte[7];
      txSh <= {txByte[6:0], 1'b0};
      bitCnt <= 3'h0;
      halfCnt <= 2'h0;
    end
    else if (busy && !pause)
    begin
      if (halfCnt == 2'(SCK_HALF - 1))
      begin
        halfCnt <= 2'h0;
        serClk <= !serClk;
        if (!serClk)
          rxByte <= {rxByte[6:0], serIn};
        else if (bitCnt == 3'h7)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          bitCnt <= bitCnt + 3'h1;
          serOut <= txSh[7];
          txSh <= {txSh[6:0], 1'b0};
        end
      end
      else
        halfCnt <= halfCnt + 2'h1;
    end
  end
endmodule

//--- rtl/sfct_host.sv
// Host sequencer that drives a serial flash through its pins
`timescale 1ns/1ps
module sfct_host
  import sfct_pkg::*;
#(
  parameter longint PWRUP_CYCLES = PWRUP_CYC,
  parameter longint STATUS_WR_CYCLES = STATUS_WR_CYC,
  parameter longint PAGE_PROG_CYCLES = PAGE_PROG_CYC,
  parameter longint SMALL_WIPE_CYCLES = SMALL_WIPE_CYC,
  parameter longint BLOCK_WIPE_CYCLES = BLOCK_WIPE_CYC,
  parameter longint ARRAY_WIPE_CYCLES = ARRAY_WIPE_CYC
)
(
  input wire logic ref_clk, // Clock, 20 MHz
  input wire logic nrst, // Sync reset, low
  input wire logic reqValid, // Request strobe
  input wire logic [3:0] reqCode, // Request kind
  input wire logic [23:0] reqAddr, // Flash address
  input wire logic [7:0] reqData, // Write byte
  input wire logic [8:0] reqLen, // Bytes to move, 1..256
  input wire logic hostPause, // Pause the transfer
  input wire logic wrValid, // Program byte valid
  input wire logic [7:0] wrData, // Program byte
  input wire logic flashSo, // Serial data from flash
  output logic reqReady, // Idle, accepts request
  output logic wrTake, // Program byte consumed
  output logic rdValid, // Read byte pulse
  output logic [7:0] rdData, // Read byte
  output logic opDone, // Operation end pulse
  output logic opTimeout, // Busy timeout flag on done
  output logic flashCsN, // Flash select, low
  output logic flashSck, // Flash serial clock
  output logic flashSi, // Serial data to flash
  output logic flashHoldN // Flash pause, low
);
  typedef enum logic [6:0] {
    ST_PWRUP = 7'b000_0001,
    ST_IDLE = 7'b000_0010,
    ST_SEND = 7'b000_0100,
    ST_GAP = 7'b000_1000,
    ST_POLL = 7'b001_0000,
    ST_WAIT = 7'b010_0000,
    ST_FIN = 7'b100_0000
  } sfct_state_t;

  sfct_state_t state;
  logic [3:0] code;
  logic [23:0] addr;
  logic [7:0] dataB;
  logic [8:0] len;
  logic [3:0] phase;
  logic [8:0] dataCnt;
  logic [35:0] timer;
  logic [35:0] busyLimit;
  logic [9:0] gapCnt;
  logic pollPhase;
  logic shStart;
  logic [7:0] shTx;
  logic shBusy;
  logic shDone;
  logic [7:0] shRx;
  logic shSck;
  logic shSi;
  logic [3:0] hdrLen;
  logic [7:0] opcode;
  logic isRead;
  logic isProg;
  logic needPoll;
  logic [7:0] next_tx;
  logic pausePrev;

  // ==========================================================
  // Serial byte engine
  sfct_shifter u_shift (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(shStart),
    .txByte(shTx),
    .pause(hostPause),
    .serIn(flashSo),
    .busy(shBusy),
    .done(shDone),
    .rxByte(shRx),
    .serClk(shSck),
    .serOut(shSi)
  );

  // ==========================================================
  // Opcode and frame shape for the held request
  always_comb
  begin
    opcode = write_latch_set_cmd;
    hdrLen = 4'd1;
    isRead = 1'b0;
    isProg = 1'b0;
    needPoll = 1'b0;
    busyLimit = 36'(STATUS_WR_CYCLES);
    unique case (code)
      REQ_LATCH_SET: opcode = write_latch_set_cmd;
      REQ_LATCH_CLR: opcode = write_latch_clear_cmd;
      REQ_STATUS_WR:
      begin
        opcode = status_write_cmd;
        hdrLen = 4'd2;
        needPoll = 1'b1;
        busyLimit = 36'(STATUS_WR_CYCLES);
      end
      REQ_READ:
      begin
        opcode = fast_read_cmd;
        hdrLen = 4'd5;
        isRead = 1'b1;
      end
      REQ_SMALL_WIPE:
      begin
        opcode = small_area_wipe_cmd;
        hdrLen = 4'd4;
        needPoll = 1'b1;
        busyLimit = 36'(SMALL_WIPE_CYCLES);
      end
      REQ_BLOCK_WIPE:
      begin
        opcode = dataB[0] ? block_wipe_alt_cmd : block_wipe_cmd;
        hdrLen = 4'd4;
        needPoll = 1'b1;
        busyLimit = 36'(BLOCK_WIPE_CYCLES);
      end
      REQ_ARRAY_WIPE:
      begin
        opcode = dataB[0] ? array_wipe_alt_cmd : array_wipe_cmd;
        needPoll = 1'b1;
        busyLimit = 36'(ARRAY_WIPE_CYCLES);
      end
      REQ_PROGRAM:
      begin
        opcode = page_program_cmd;
        hdrLen = 4'd4;
        isProg = 1'b1;
        needPoll = 1'b1;
        busyLimit = 36'(PAGE_PROG_CYCLES);
      end
      REQ_SLEEP:
      begin
        opcode = deep_sleep_cmd;
        busyLimit = 36'(SLEEP_CYC);
      end
      REQ_WAKE:
      begin
        opcode = wake_cmd;
        busyLimit = 36'(WAKE_CYC);
      end
      REQ_SEC_WR:
      begin
        opcode = security_word_write_cmd;
        needPoll = 1'b1;
        busyLimit = 36'(STATUS_WR_CYCLES);
      end
      REQ_ID_READ:
      begin
        opcode = maker_part_id_read_cmd;
        hdrLen = 4'd4;
        isRead = 1'b1;
      end
      default: opcode = write_latch_set_cmd;
    endcase
  end

  // Byte to shift out at the current phase
  always_comb
  begin
    next_tx = 8'h00;
    if (state == ST_POLL)
      next_tx = status_read_cmd;
    else if (phase == 4'd0)
      next_tx = opcode;
    else if (code == REQ_STATUS_WR)
      next_tx = dataB;
    else if (phase == 4'd1)
      next_tx = addr[23:16];
    else if (phase == 4'd2)
      next_tx = addr[15:8];
    else if (phase == 4'd3)
      next_tx = (code == REQ_ID_READ) ? {7'h00, addr[0]} : addr[7:0];
    else if (isProg && phase >= hdrLen)
      next_tx = wrData;
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge ref_clk)
  begin
    shStart <= 1'b0;
    wrTake <= 1'b0;
    rdValid <= 1'b0;
    opDone <= 1'b0;
    if (!nrst)
    begin
      state <= ST_PWRUP;
      code <= REQ_LATCH_SET;
      addr <= 24'h00_0000;
      dataB <= 8'h00;
      len <= 9'h001;
      phase <= 4'h0;
      dataCnt <= 9'h000;
      timer <= 36'h0_0000_0000;
      gapCnt <= 10'h000;
      pollPhase <= 1'b0;
      shTx <= 8'h00;
      reqReady <= 1'b0;
      rdData <= 8'h00;
      opTimeout <= 1'b0;
      flashCsN <= 1'b1;
    end
    else
    begin
      unique case (state)
        ST_PWRUP:
        begin
          timer <= timer + 36'h1;
          if (timer >= 36'(PWRUP_CYCLES))
          begin
            timer <= 36'h0;
            state <= ST_IDLE;
            reqReady <= 1'b1;
          end
        end
        ST_IDLE:
          if (reqValid)
          begin
            code <= reqCode;
            addr <= reqAddr;
            dataB <= reqData;
            len <= (reqLen == 9'h000) ? 9'h001 : reqLen;
            phase <= 4'h0;
            dataCnt <= 9'h000;
            opTimeout <= 1'b0;
            reqReady <= 1'b0;
            flashCsN <= 1'b0;
            state <= ST_SEND;
          end
        ST_SEND:
          if (!shBusy && !shStart)
          begin
            if (phase > 4'd0 && isRead && phase > hdrLen)
            begin
              rdData <= shRx;
              rdValid <= 1'b1;
              dataCnt <= dataCnt + 9'h1;
            end
            if (phase < hdrLen || (isRead && phase >= hdrLen
                && (phase == hdrLen || dataCnt + 9'h1 < len)))
            begin
              shTx <= next_tx;
              shStart <= 1'b1;
              phase <= (phase < 4'd15) ? phase + 4'h1 : phase;
            end
            else if (isProg && dataCnt < len)
            begin
              if (wrValid)
              begin
                shTx <= next_tx;
                shStart <= 1'b1;
                wrTake <= 1'b1;
                dataCnt <= dataCnt + 9'h1;
              end
            end
            else
            begin
              flashCsN <= 1'b1;
              timer <= 36'h0;
              gapCnt <= 10'h000;
              state <= needPoll ? ST_GAP : ((code == REQ_SLEEP || code == REQ_WAKE)
                                           ? ST_WAIT : ST_FIN);
            end
          end
        ST_GAP:
        begin
          timer <= timer + 36'h1;
          gapCnt <= gapCnt + 10'h1;
          if (timer >= busyLimit)
          begin
            opTimeout <= 1'b1;
            state <= ST_FIN;
          end
          else if (gapCnt == POLL_GAP_CYC)
          begin
            flashCsN <= 1'b0;
            pollPhase <= 1'b0;
            shTx <= status_read_cmd;
            shStart <= 1'b1;
            state <= ST_POLL;
          end
        end
        ST_POLL:
        begin
          timer <= timer + 36'h1;
          if (!shBusy && !shStart)
          begin
            if (!pollPhase)
            begin
              pollPhase <= 1'b1;
              shTx <= 8'h00;
              shStart <= 1'b1;
            end
            else
            begin
              flashCsN <= 1'b1;
              gapCnt <= 10'h000;
              state <= shRx[0] ? ST_GAP : ST_FIN;
            end
          end
        end
        ST_WAIT:
        begin
          timer <= timer + 36'h1;
          if (timer + 36'h1 >= busyLimit)
            state <= ST_FIN;
        end
        ST_FIN:
        begin
          opDone <= 1'b1;
          reqReady <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pins from flops
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      flashSck <= 1'b0;
      flashSi <= 1'b0;
      flashHoldN <= 1'b1;
      pausePrev <= 1'b0;
    end
    else
    begin
      flashSck <= shSck;
      flashSi <= shSi;
      // Hold falls a cycle after the engine freezes, so no clock edge meets it
      flashHoldN <= !(hostPause && pausePrev);
      pausePrev <= hostPause;
    end
  end

  // ==========================================================
  // Checks
  a_select_high_powerup: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ST_PWRUP) |-> flashCsN)
    else $error("select low during power-up");
  a_sleep_wait_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($rose(state == ST_WAIT) && code == REQ_SLEEP) |-> (state == ST_WAIT) [*8])
    else $error("deep sleep wait too short");
  a_wake_wait_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($rose(state == ST_WAIT) && code == REQ_WAKE) |-> ##[170:180] (state == ST_FIN))
    else $error("wake wait wrong length");
  a_sck_hold_pause: assert property (@(posedge ref_clk) disable iff (!nrst)
    (hostPause && $past(hostPause)) |=> $stable(flashSck))
    else $error("clock moved while paused");
  a_wipe_alt_code: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ST_SEND && shStart && phase == 4'd1 && code == REQ_BLOCK_WIPE) |->
    (shTx == (dataB[0] ? block_wipe_alt_cmd : block_wipe_cmd))) else $error("block wipe code");
  a_timeout_limit: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == ST_GAP && timer >= busyLimit) |=> (opTimeout && state == ST_FIN))
    else $error("busy limit not enforced");
endmodule

//--- tb/sfct_flash_model.sv
// Behavioural serial flash that answers the host sequencer
`timescale 1ns/1ps
module sfct_flash_model
  import sfct_pkg::*;
#(
  parameter real T_PWR_NS = 5000.0,
  parameter logic [7:0] MAKER_ID = 8'hC3, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h5E // Arbitrary value
)
(
  input wire logic ref_clk, // Paces idle pattern
  input wire logic csN, // Select, low
  input wire logic sck, // Serial clock
  input wire logic si, // Data in
  input wire logic holdN, // Pause, low
  input wire logic stuck, // Stay busy forever
  output logic so // Data out
);
  logic [7:0] frame [0:7];
  logic [7:0] sh = 8'h00;
  logic [7:0] op = 8'h00;
  logic [7:0] stat = 8'h00;
  logic [7:0] outB = 8'h00;
  logic latch = 1'b0;
  logic asleep = 1'b0;
  int bits = 0;
  int busyPolls = 0;
  int viol = 0;
  int obit = 7;
  realtime tRise = 0.0;
  initial so = 1'b0;
  // ==========================================================
  // Byte decode
  task automatic take_byte(input int idx);
    if (idx == 0)
    begin
      if (busyPolls > 0 && !stuck && sh != status_read_cmd)
        viol++;
      op = (asleep && sh != wake_cmd) ? 8'hFF : sh;
      if (op != status_read_cmd)
        foreach (frame[i]) frame[i] = 8'h00;
    end
    if (op != status_read_cmd && idx < 8)
      frame[idx] = sh;
    obit = 7;
    if (op == status_read_cmd)
      outB = {7'h00, stuck || busyPolls > 0};
    else if (op == fast_read_cmd && idx >= 4)
      outB = frame[3] + 8'(idx - 4);
    else if (op == maker_part_id_read_cmd && idx >= 3)
      outB = (frame[3][0] ^ ~idx[0]) ? PART_ID : MAKER_ID;
  endtask
  // ==========================================================
  // Data line toggles while deselected, never a stale level
  always @(posedge ref_clk)
  begin
    if (csN)
      so <= ~so;
  end
  // ==========================================================
  // Selection edges and command effects
  always @(negedge csN)
  begin
    if ($realtime < T_PWR_NS)
      viol++;
    if (op == deep_sleep_cmd && $realtime - tRise < 10000.0)
      viol++;
    if (op == wake_cmd && $realtime - tRise < 8800.0)
      viol++;
    bits = 0;
  end
  always @(posedge csN)
  begin
    tRise = $realtime;
    if (op == status_read_cmd && busyPolls > 0)
      busyPolls--;
    else if (op == write_latch_set_cmd)
      latch = 1'b1;
    else if (op == write_latch_clear_cmd)
      latch = 1'b0;
    else if (op == deep_sleep_cmd)
      asleep = 1'b1;
    else if (op == wake_cmd)
      asleep = 1'b0;
    else if (latch && op inside {status_write_cmd, small_area_wipe_cmd, block_wipe_cmd,
        block_wipe_alt_cmd, array_wipe_cmd, array_wipe_alt_cmd, page_program_cmd,
        security_word_write_cmd})
    begin
      busyPolls = 1;
      latch = 1'b0;
      if (op == status_write_cmd)
        stat = frame[1];
    end
  end
  // ==========================================================
  // Shift in on rising clock, out on falling clock
  always @(posedge sck)
  begin
    if (!csN && holdN)
    begin
      sh = {sh[6:0], si};
      bits++;
      if (bits % 8 == 0)
        take_byte(bits / 8 - 1);
    end
  end
  always @(negedge sck)
  begin
    if (!csN && holdN)
    begin
      so <= outB[obit];
      obit = (obit + 7) % 8;
    end
  end
endmodule

//--- tb/serial_flash_command_timing_test.sv
// Self-checking bench for the serial flash host sequencer
`timescale 1ns/1ps
module serial_flash_command_timing_test;
  import sfct_pkg::*;
  typedef struct packed {
    logic [3:0] code;
    logic arm;
    logic [23:0] addr;
    logic [7:0] data;
    logic [7:0] expCmd;
    logic [7:0] expSec;
  } sfct_row_t;
  sfct_row_t rows [0:8] = '{
    '{REQ_LATCH_SET, 1'b0, 24'h00_0000, 8'h00, 8'h06, 8'h00},
    '{REQ_LATCH_CLR, 1'b0, 24'h00_0000, 8'h00, 8'h04, 8'h00},
    '{REQ_STATUS_WR, 1'b1, 24'h00_0000, 8'h3C, 8'h01, 8'h3C},
    '{REQ_SMALL_WIPE, 1'b1, 24'h12_3456, 8'h00, 8'h20, 8'h12},
    '{REQ_BLOCK_WIPE, 1'b1, 24'h65_4321, 8'h00, 8'h52, 8'h65},
    '{REQ_BLOCK_WIPE, 1'b1, 24'h65_4321, 8'h01, 8'hD8, 8'h65},
    '{REQ_ARRAY_WIPE, 1'b1, 24'h00_0000, 8'h00, 8'h60, 8'h00},
    '{REQ_ARRAY_WIPE, 1'b1, 24'h00_0000, 8'h01, 8'hC7, 8'h00},
    '{REQ_SEC_WR, 1'b1, 24'h00_0000, 8'h00, 8'h2F, 8'h00}};
  localparam logic [7:0] MAKER = 8'hC3; // Arbitrary value
  localparam logic [7:0] PART = 8'h5E; // Arbitrary value
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic reqValid = 1'b0;
  logic [3:0] reqCode = 4'h0;
  logic [23:0] reqAddr = 24'h00_0000;
  logic [7:0] reqData = 8'h00;
  logic [8:0] reqLen = 9'h001;
  logic hostPause = 1'b0;
  logic wrValid = 1'b1;
  logic [7:0] wrData = 8'hA5;
  logic stuck = 1'b0;
  logic flashSo, reqReady, wrTake, rdValid, opDone, opTimeout;
  logic flashCsN, flashSck, flashSi, flashHoldN;
  logic [7:0] rdData;
  logic [7:0] progB [0:1] = '{8'hA5, 8'h5A};
  logic [7:0] rdQ [$];
  int miscompares = 0;
  int checksDone = 0;
  always #25 ref_clk = ~ref_clk;
  sfct_host #(.PWRUP_CYCLES(100), .SMALL_WIPE_CYCLES(4000)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid), .reqCode(reqCode),
    .reqAddr(reqAddr), .reqData(reqData), .reqLen(reqLen), .hostPause(hostPause),
    .wrValid(wrValid), .wrData(wrData), .flashSo(flashSo), .reqReady(reqReady),
    .wrTake(wrTake), .rdValid(rdValid), .rdData(rdData), .opDone(opDone),
    .opTimeout(opTimeout), .flashCsN(flashCsN), .flashSck(flashSck), .flashSi(flashSi),
    .flashHoldN(flashHoldN));
  sfct_flash_model #(.T_PWR_NS(5000.0), .MAKER_ID(MAKER), .PART_ID(PART)) u_flash (
    .ref_clk(ref_clk), .csN(flashCsN), .sck(flashSck), .si(flashSi), .holdN(flashHoldN),
    .stuck(stuck), .so(flashSo));
  always @(posedge ref_clk)
  begin
    if (rdValid === 1'b1)
      rdQ.push_back(rdData);
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_op(input logic [3:0] c, input logic [23:0] a, input logic [7:0] d,
      input logic [8:0] n);
    int k;
    int wi;
    logic done;
    k = 0;
    wi = 0;
    done = 1'b0;
    while (reqReady !== 1'b1 && k < 9000)
    begin
      @(posedge ref_clk);
      #2;
      k++;
    end
    reqValid = 1'b1;
    reqCode = c;
    reqAddr = a;
    reqData = d;
    reqLen = n;
    wrData = progB[0];
    @(posedge ref_clk);
    #2;
    reqValid = 1'b0;
    for (k = 0; k < 12000 && !done; k++)
    begin
      @(posedge ref_clk);
      if (wrTake === 1'b1)
        wi++;
      done = (opDone === 1'b1);
      #2;
      wrData = progB[wi % 2];
    end
    check("op done", done, 1'b1);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    @(posedge ref_clk);
    #2;
    check("ready in reset", reqReady, 1'b0);
    check("select in reset", flashCsN, 1'b1);
    @(posedge ref_clk);
    #2;
    nrst = 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].arm)
        do_op(REQ_LATCH_SET, 24'h00_0000, 8'h00, 9'h001);
      do_op(rows[i].code, rows[i].addr, rows[i].data, 9'h001);
      check("command", u_flash.frame[0], rows[i].expCmd);
      check("second byte", u_flash.frame[1], rows[i].expSec);
      check("latch", u_flash.latch, rows[i].code == REQ_LATCH_SET);
      check("timeout", opTimeout, 1'b0);
    end
    check("status", u_flash.stat, 8'h3C);
    do_op(REQ_LATCH_SET, 24'h00_0000, 8'h00, 9'h001);
    fork
      do_op(REQ_STATUS_WR, 24'h00_0000, 8'h5A, 9'h001);
      begin
        repeat (20) @(posedge ref_clk);
        #2;
        hostPause = 1'b1;
        repeat (3) @(posedge ref_clk);
        #2;
        check("pause pin", flashHoldN, 1'b0);
        repeat (30) @(posedge ref_clk);
        #2;
        hostPause = 1'b0;
      end
    join
    check("paused status", u_flash.stat, 8'h5A);
    do_op(REQ_LATCH_CLR, 24'h00_0000, 8'h00, 9'h001);
    do_op(REQ_STATUS_WR, 24'h00_0000, 8'h99, 9'h001);
    check("refused status", u_flash.stat, 8'h5A);
    rdQ.delete();
    do_op(REQ_READ, 24'h00_0040, 8'h00, 9'h003);
    check("read count", rdQ.size(), 3);
    for (int k = 0; k < 3 && k < rdQ.size(); k++)
      check("read byte", rdQ[k], 8'h40 + k);
    for (int a = 0; a < 2; a++)
    begin
      rdQ.delete();
      do_op(REQ_ID_READ, 24'(a), 8'h00, 9'h002);
      check("id count", rdQ.size(), 2);
      check("id first", rdQ[0], a ? PART : MAKER);
    end
    do_op(REQ_LATCH_SET, 24'h00_0000, 8'h00, 9'h001);
    do_op(REQ_PROGRAM, 24'h00_0100, 8'h00, 9'h002);
    check("program cmd", u_flash.frame[0], 8'h02);
    check("program byte 0", u_flash.frame[4], 8'hA5);
    check("program byte 1", u_flash.frame[5], 8'h5A);
    do_op(REQ_SLEEP, 24'h00_0000, 8'h00, 9'h001);
    check("sleep cmd", u_flash.frame[0], 8'hB9);
    do_op(REQ_WAKE, 24'h00_0000, 8'h00, 9'h001);
    check("wake cmd", u_flash.frame[0], 8'hAB);
    do_op(REQ_LATCH_SET, 24'h00_0000, 8'h00, 9'h001);
    check("latch after wake", u_flash.latch, 1'b1);
    stuck = 1'b1;
    do_op(REQ_SMALL_WIPE, 24'h00_1000, 8'h00, 9'h001);
    check("busy timeout", opTimeout, 1'b1);
    stuck = 1'b0;
    check("far side timing", u_flash.viol, 0);
    report_and_stop();
  end
  initial
  begin
    #(100000 * 50);
    miscompares++;
    report_and_stop();
  end
endmodule
